// File: rpo_pkg.sv
// Package for the remappable pin output select block: map, reset values, decode.
// Assumes a 32-bit AXI4-Lite register bus with 8 address bits.
`default_nettype none
package rpo_pkg;
   localparam int          NUM_PINS  = 4;
   localparam int          CODE_W    = 5;
   localparam int          NUM_FUNC  = 32;
   localparam int          ADDR_W    = 8;
   // Byte offsets
   localparam logic [7:0]  OFS_OSEL_A = 8'h00;
   localparam logic [7:0]  OFS_OSEL_B = 8'h04;
   localparam logic [7:0]  OFS_ANSEL  = 8'h08;
   localparam logic [7:0]  OFS_DIR    = 8'h0C;
   localparam logic [7:0]  OFS_LAT    = 8'h10;
   localparam logic [7:0]  OFS_PORT   = 8'h14;
   localparam logic [7:0]  OFS_PU     = 8'h18;
   localparam logic [7:0]  OFS_PD     = 8'h1C;
   // Field positions in the output-select registers
   localparam int          LO_FIELD_LSB = 0;
   localparam int          HI_FIELD_LSB = 8;
   // Reset values and bus response codes
   localparam logic [4:0]  CODE_RST     = 5'h00;
   localparam logic [3:0]  ANSEL_DEF    = 4'hF;
   localparam logic [3:0]  DIR_RST      = 4'hF;
   localparam logic [3:0]  LAT_RST      = 4'h0;
   localparam logic [3:0]  PULL_RST     = 4'h0;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;

   typedef enum logic [3:0] {
      IDX_OSEL_A, IDX_OSEL_B, IDX_ANSEL, IDX_DIR, IDX_LAT, IDX_PORT, IDX_PU, IDX_PD, IDX_NONE
   } rpo_idx_t;

   function automatic rpo_idx_t rpo_decode(input logic [7:0] addr);
      logic [7:0] a;
      a = {addr[7:2], 2'h0};
      case (a)
         OFS_OSEL_A: rpo_decode = IDX_OSEL_A;
         OFS_OSEL_B: rpo_decode = IDX_OSEL_B;
         OFS_ANSEL:  rpo_decode = IDX_ANSEL;
         OFS_DIR:    rpo_decode = IDX_DIR;
         OFS_LAT:    rpo_decode = IDX_LAT;
         OFS_PORT:   rpo_decode = IDX_PORT;
         OFS_PU:     rpo_decode = IDX_PU;
         OFS_PD:     rpo_decode = IDX_PD;
         default:    rpo_decode = IDX_NONE;
      endcase
   endfunction
endpackage
`default_nettype wire

// File: rpo_sync2.sv
// Two-flop synchroniser for pin levels.
// Assumes inputs are asynchronous to clk; first stage is read only by the second.
`timescale 1ns/100ps
`default_nettype none
module rpo_sync2 #(
   parameter int W = 4
) (
   // Clock and control
   input  wire logic          clk,
   input  wire logic          rst_n,
   input  wire logic          ce,
   // Data
   input  wire logic [W-1:0]  d,
   output logic      [W-1:0]  q
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta_q <= '0;
         sync_q <= '0;
      end else if (ce) begin
         meta_q <= d;
         sync_q <= meta_q;
      end
   end

   assign q = sync_q;
endmodule // rpo_sync2
`default_nettype wire

// File: rpo_pin_sel.sv
// Per-pin output function selection with fixed priority.
// Assumes all function sources are on the system clock.
`timescale 1ns/100ps
`default_nettype none
module rpo_pin_sel (
   // Function sources
   input  wire logic                          ded_en,
   input  wire logic                          ded_out,
   input  wire logic [rpo_pkg::CODE_W-1:0]    func_code,
   input  wire logic [rpo_pkg::NUM_FUNC-1:0]  periph_out,
   input  wire logic                          latch,
   input  wire logic                          dir,
   // Selection result
   output logic                               pin_out,
   output logic                               pin_oe,
   output logic                               remap_val,
   output logic                               gpio_only
);
   logic remap_on;

   // Code zero means no remapped function
   assign remap_on  = |func_code;
   assign remap_val = periph_out[func_code];
   assign gpio_only = ~ded_en & ~remap_on;
   // One source only: dedicated, then remapped, then latch
   assign pin_out   = ded_en ? ded_out : (remap_on ? remap_val : latch);
   // Active peripheral output overrides the direction bit
   assign pin_oe    = ded_en | remap_on | ~dir;
endmodule // rpo_pin_sel
`default_nettype wire

// File: rpo_pin_output_select.sv
// Remappable pin output select for pins 12 to 15, with analog, pull and GPIO control.
// Assumes an AXI4-Lite master on CLK_SYS and pins that are asynchronous to it.
// Behaviour
// - pin 13 takes function from select bits 12:8
// - pin 12 from bits 4:0; 7:5 read zero
// - shared analog pins start analog after reset
// - analog pin disables its digital input buffer
// - analog pin reads zero in port and latch
// - writing analog bit zero enables digital input
// - direction zero still drives output when analog
// - functions ranked in fixed naming-order priority
// - higher-priority function disables all lower ones
// - dedicated above remappable; GPIO lowest of all
// - per-pin weak pull-up and pull-down enables
// - only one output function drives a pin
// - peripheral output overrides the direction bit
// - many input functions may share one pin
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module rpo_pin_output_select #(
   parameter logic [3:0] ANALOG_PINS = rpo_pkg::ANSEL_DEF
) (
   // Clock, reset, enable
   input  wire logic                          CLK_SYS,
   input  wire logic                          RSTN,
   input  wire logic                          CE,
   // AXI4-Lite write address
   input  wire logic                          AWVALID,
   output logic                               AWREADY,
   input  wire logic [rpo_pkg::ADDR_W-1:0]    AWADDR,
   input  wire logic [2:0]                    AWPROT,
   // AXI4-Lite write data
   input  wire logic                          WVALID,
   output logic                               WREADY,
   input  wire logic [31:0]                   WDATA,
   input  wire logic [3:0]                    WSTRB,
   // AXI4-Lite write response
   output logic                               BVALID,
   input  wire logic                          BREADY,
   output logic      [1:0]                    BRESP,
   // AXI4-Lite read address
   input  wire logic                          ARVALID,
   output logic                               ARREADY,
   input  wire logic [rpo_pkg::ADDR_W-1:0]    ARADDR,
   input  wire logic [2:0]                    ARPROT,
   // AXI4-Lite read data
   output logic                               RVALID,
   input  wire logic                          RREADY,
   output logic      [31:0]                   RDATA,
   output logic      [1:0]                    RRESP,
   // On-chip function sources
   input  wire logic [rpo_pkg::NUM_FUNC-1:0]  PERIPH_OUT,
   input  wire logic [rpo_pkg::NUM_PINS-1:0]  DED_OUT_EN,
   input  wire logic [rpo_pkg::NUM_PINS-1:0]  DED_OUT,
   // Digital input to peripherals
   output logic      [rpo_pkg::NUM_PINS-1:0]  DIG_IN,
   // Pins
   input  wire logic [rpo_pkg::NUM_PINS-1:0]  PIN_IN,
   output logic      [rpo_pkg::NUM_PINS-1:0]  PIN_OUT,
   output logic      [rpo_pkg::NUM_PINS-1:0]  PIN_OE,
   output logic      [rpo_pkg::NUM_PINS-1:0]  PIN_PU_EN,
   output logic      [rpo_pkg::NUM_PINS-1:0]  PIN_PD_EN,
   output logic      [rpo_pkg::NUM_PINS-1:0]  PIN_ANALOG_EN
);
   localparam int NP = rpo_pkg::NUM_PINS;

   // Register state
   logic [rpo_pkg::CODE_W-1:0] sel_q [NP];
   logic [NP-1:0]              ana_q;
   logic [NP-1:0]              dir_q;
   logic [NP-1:0]              lat_q;
   logic [NP-1:0]              pu_q;
   logic [NP-1:0]              pd_q;
   // Pin-side state
   logic [NP-1:0]              pin_out_q;
   logic [NP-1:0]              pin_oe_q;
   logic [NP-1:0]              dig_in_q;
   logic [NP-1:0]              pin_s;
   // Bus state
   logic                       aw_got_q;
   logic                       w_got_q;
   logic [rpo_pkg::ADDR_W-1:0] awaddr_q;
   logic [31:0]                wdata_q;
   logic [3:0]                 wstrb_q;
   logic                       bvalid_q;
   logic [1:0]                 bresp_q;
   logic                       rvalid_q;
   logic [31:0]                rdata_q;
   logic [1:0]                 rresp_q;
   // Selection results
   logic [NP-1:0]              mux_out;
   logic [NP-1:0]              mux_oe;
   logic [NP-1:0]              remap_val;
   logic [NP-1:0]              gpio_mask;

   // Pins cross into CLK_SYS through two flops
   rpo_sync2 #(.W(NP)) u_sync (
      .clk   (CLK_SYS),
      .rst_n (RSTN),
      .ce    (CE),
      .d     (PIN_IN),
      .q     (pin_s)
   );

   genvar g;
   generate
      for (g = 0; g < NP; g++) begin : g_pin
         rpo_pin_sel u_sel (
            .ded_en     (DED_OUT_EN[g]),
            .ded_out    (DED_OUT[g]),
            .func_code  (sel_q[g]),
            .periph_out (PERIPH_OUT),
            .latch      (lat_q[g]),
            .dir        (dir_q[g]),
            .pin_out    (mux_out[g]),
            .pin_oe     (mux_oe[g]),
            .remap_val  (remap_val[g]),
            .gpio_only  (gpio_mask[g])
         );
      end
   endgenerate

   // Handshake and write decode
   wire                   aw_hs   = AWVALID & AWREADY;
   wire                   w_hs    = WVALID & WREADY;
   wire                   ar_hs   = ARVALID & ARREADY;
   wire                   wr_do   = CE & aw_got_q & w_got_q & ~bvalid_q;
   wire rpo_pkg::rpo_idx_t wr_idx = rpo_pkg::rpo_decode(awaddr_q);
   wire rpo_pkg::rpo_idx_t rd_idx = rpo_pkg::rpo_decode(ARADDR);
   wire [7:0]             wb0     = wstrb_q[0] ? wdata_q[7:0] : 8'h00;
   wire [7:0]             wb1     = wstrb_q[1] ? wdata_q[15:8] : 8'h00;
   wire                   wr_lo   = wr_do & wstrb_q[0];
   wire                   wr_hi   = wr_do & wstrb_q[1];
   wire                   wr_err  = (wr_idx == rpo_pkg::IDX_NONE);

   // Ready only while CE runs, so no handshake is lost in a freeze
   assign AWREADY = CE & ~aw_got_q & ~bvalid_q;
   assign WREADY  = CE & ~w_got_q & ~bvalid_q;
   assign ARREADY = CE & ~rvalid_q;
   assign BVALID  = bvalid_q;
   assign BRESP   = bresp_q;
   assign RVALID  = rvalid_q;
   assign RDATA   = rdata_q;
   assign RRESP   = rresp_q;

   always_ff @(posedge CLK_SYS) begin
      if (!RSTN) begin
         aw_got_q <= 1'b0;
         awaddr_q <= 8'h00;
      end else if (CE) begin
         if (aw_hs) begin
            aw_got_q <= 1'b1;
            awaddr_q <= AWADDR;
         end else if (wr_do) begin
            aw_got_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RSTN) begin
         w_got_q <= 1'b0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else if (CE) begin
         if (w_hs) begin
            w_got_q <= 1'b1;
            wdata_q <= WDATA;
            wstrb_q <= WSTRB;
         end else if (wr_do) begin
            w_got_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RSTN) begin
         bvalid_q <= 1'b0;
         bresp_q  <= rpo_pkg::RESP_OKAY;
      end else if (CE) begin
         if (wr_do) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_err ? rpo_pkg::RESP_SLVERR : rpo_pkg::RESP_OKAY;
         end else if (BREADY) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // Output-select fields; reserved bits are never stored
   always_ff @(posedge CLK_SYS) begin
      if (!RSTN) begin
         for (int i = 0; i < NP; i++) begin
            sel_q[i] <= rpo_pkg::CODE_RST;
         end
      end else begin
         if (wr_lo && wr_idx == rpo_pkg::IDX_OSEL_A) sel_q[0] <= wb0[4:0];
         if (wr_hi && wr_idx == rpo_pkg::IDX_OSEL_A) sel_q[1] <= wb1[4:0];
         if (wr_lo && wr_idx == rpo_pkg::IDX_OSEL_B) sel_q[2] <= wb0[4:0];
         if (wr_hi && wr_idx == rpo_pkg::IDX_OSEL_B) sel_q[3] <= wb1[4:0];
      end
   end

   // Control registers; analog bits exist only on shared pins
   always_ff @(posedge CLK_SYS) begin
      if (!RSTN) begin
         ana_q <= ANALOG_PINS;
         dir_q <= rpo_pkg::DIR_RST;
         lat_q <= rpo_pkg::LAT_RST;
         pu_q  <= rpo_pkg::PULL_RST;
         pd_q  <= rpo_pkg::PULL_RST;
      end else if (wr_lo) begin
         if (wr_idx == rpo_pkg::IDX_ANSEL) ana_q <= wb0[3:0] & ANALOG_PINS;
         if (wr_idx == rpo_pkg::IDX_DIR) dir_q <= wb0[3:0];
         if (wr_idx == rpo_pkg::IDX_LAT || wr_idx == rpo_pkg::IDX_PORT) lat_q <= wb0[3:0];
         if (wr_idx == rpo_pkg::IDX_PU) pu_q <= wb0[3:0];
         if (wr_idx == rpo_pkg::IDX_PD) pd_q <= wb0[3:0];
      end
   end

   // Read mux; analog pins read zero in port and latch
   wire [31:0] rd_data =
      (rd_idx == rpo_pkg::IDX_OSEL_A) ? {16'h0000, 3'h0, sel_q[1], 3'h0, sel_q[0]} :
      (rd_idx == rpo_pkg::IDX_OSEL_B) ? {16'h0000, 3'h0, sel_q[3], 3'h0, sel_q[2]} :
      (rd_idx == rpo_pkg::IDX_ANSEL)  ? {28'h0000000, ana_q} :
      (rd_idx == rpo_pkg::IDX_DIR)    ? {28'h0000000, dir_q} :
      (rd_idx == rpo_pkg::IDX_LAT)    ? {28'h0000000, lat_q & ~ana_q} :
      (rd_idx == rpo_pkg::IDX_PORT)   ? {28'h0000000, pin_s & ~ana_q} :
      (rd_idx == rpo_pkg::IDX_PU)     ? {28'h0000000, pu_q} :
      (rd_idx == rpo_pkg::IDX_PD)     ? {28'h0000000, pd_q} : 32'h0000_0000;

   always_ff @(posedge CLK_SYS) begin
      if (!RSTN) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= rpo_pkg::RESP_OKAY;
      end else if (CE) begin
         if (ar_hs) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_data;
            rresp_q  <= (rd_idx == rpo_pkg::IDX_NONE) ? rpo_pkg::RESP_SLVERR : rpo_pkg::RESP_OKAY;
         end else if (RREADY) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   // Pin drive and digital input; digital output still allowed on analog pins
   always_ff @(posedge CLK_SYS) begin
      if (!RSTN) begin
         pin_out_q <= rpo_pkg::LAT_RST;
         pin_oe_q  <= 4'h0;
         dig_in_q  <= 4'h0;
      end else if (CE) begin
         pin_out_q <= mux_out;
         pin_oe_q  <= mux_oe;
         dig_in_q  <= pin_s & ~ana_q;
      end
   end

   assign PIN_OUT       = pin_out_q;
   assign PIN_OE        = pin_oe_q;
   assign DIG_IN        = dig_in_q;
   assign PIN_PU_EN     = pu_q;
   assign PIN_PD_EN     = pd_q;
   assign PIN_ANALOG_EN = ana_q;

   // Checks
   AST_PIN13_ROUTE: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      CE && !DED_OUT_EN[1] && sel_q[1] != 5'h00 |=> PIN_OE[1] && PIN_OUT[1] == $past(remap_val[1]))
      else $error("pin 13 not driven by its selected function");
   AST_PIN12_ROUTE: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      CE && !DED_OUT_EN[0] && sel_q[0] != 5'h00 |=> PIN_OE[0] && PIN_OUT[0] == $past(PERIPH_OUT[sel_q[0]]))
      else $error("pin 12 not driven by its selected function");
   AST_PIN15_ROUTE: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      CE && !DED_OUT_EN[3] && sel_q[3] != 5'h00 |=> PIN_OE[3] && PIN_OUT[3] == $past(PERIPH_OUT[sel_q[3]]))
      else $error("pin 15 not driven by its selected function");
   AST_PIN14_ROUTE: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      CE && !DED_OUT_EN[2] && sel_q[2] != 5'h00 |=> PIN_OE[2] && PIN_OUT[2] == $past(PERIPH_OUT[sel_q[2]]))
      else $error("pin 14 not driven by its selected function");
   AST_ANALOG_AFTER_RESET: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      !$past(RSTN) |-> PIN_ANALOG_EN == ANALOG_PINS && PIN_OE == 4'h0)
      else $error("shared pins not analog after reset");
   AST_DIGIN_GATED: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      CE |=> (DIG_IN & $past(ana_q)) == 4'h0)
      else $error("digital input seen on an analog pin");
   AST_READ_ZERO: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      ar_hs && (rd_idx == rpo_pkg::IDX_PORT || rd_idx == rpo_pkg::IDX_LAT)
      |=> RVALID && (RDATA[3:0] & $past(ana_q)) == 4'h0)
      else $error("analog pin read non-zero");
   AST_DIGIN_FOLLOWS: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      CE |=> ((DIG_IN ^ $past(pin_s)) & ~$past(ana_q)) == 4'h0)
      else $error("digital pin input not passed on");
   AST_GPIO_FALLBACK: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      CE |=> ((PIN_OE ^ ~$past(dir_q)) & $past(gpio_mask)) == 4'h0
             && ((PIN_OUT ^ $past(lat_q)) & $past(gpio_mask)) == 4'h0)
      else $error("unselected pin not under general I/O");
   AST_DED_WINS: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      CE |=> (PIN_OE & $past(DED_OUT_EN)) == $past(DED_OUT_EN)
             && ((PIN_OUT ^ $past(DED_OUT)) & $past(DED_OUT_EN)) == 4'h0)
      else $error("dedicated output did not take the pin");
   AST_ANALOG_DRIVE: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      CE && ana_q[0] && !dir_q[0] |=> PIN_OE[0])
      else $error("output dropped on analog pin");
   AST_RESERVED_ZERO: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      RVALID |-> RDATA[31:13] == 19'h00000 && RDATA[7:5] == 3'h0)
      else $error("reserved read bits not zero");
   AST_BRESP_PAIR: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      CE && aw_got_q && w_got_q && !bvalid_q |=> BVALID ##0 !AWREADY && !WREADY)
      else $error("write response not given after both channels");

   // Register writes land on the edge that raises the response
   AST_PU_WRITE: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      wr_lo && wr_idx == rpo_pkg::IDX_PU |=> PIN_PU_EN == $past(wb0[3:0]))
      else $error("pull-up enables not written");
   AST_PD_WRITE: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      wr_lo && wr_idx == rpo_pkg::IDX_PD |=> PIN_PD_EN == $past(wb0[3:0]))
      else $error("pull-down enables not written");
   AST_ANSEL_WRITE: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      wr_lo && wr_idx == rpo_pkg::IDX_ANSEL |=> PIN_ANALOG_EN == ($past(wb0[3:0]) & ANALOG_PINS))
      else $error("analog select not written");
   AST_PIN14_WRITE: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      wr_lo && wr_idx == rpo_pkg::IDX_OSEL_B |=> sel_q[2] == $past(wb0[4:0]))
      else $error("pin 14 code not written");
   AST_SEL_RESET: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      !$past(RSTN) |-> {sel_q[3], sel_q[2], sel_q[1], sel_q[0]} == 20'h00000)
      else $error("select codes not zero after reset");
   AST_DIGIN_RESET: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      !$past(RSTN) |-> DIG_IN == 4'h0 && !BVALID && !RVALID)
      else $error("outputs not idle after reset");
   AST_RDATA_HOLD: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      RVALID && !RREADY |=> RVALID && $stable(RDATA) && $stable(RRESP))
      else $error("read answer dropped before taken");
   AST_BRESP_HOLD: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      BVALID && !BREADY |=> BVALID && $stable(BRESP))
      else $error("write answer dropped before taken");

   COV_REMAP:   cover property (@(posedge CLK_SYS) disable iff (!RSTN) CE && sel_q[1] != 5'h00 ##1 PIN_OE[1]);
   COV_DED:     cover property (@(posedge CLK_SYS) disable iff (!RSTN) CE && DED_OUT_EN[0] && sel_q[0] != 5'h00);
   COV_DIGITAL: cover property (@(posedge CLK_SYS) disable iff (!RSTN) $fell(ana_q[2]));
   COV_RD_PORT: cover property (@(posedge CLK_SYS) disable iff (!RSTN) ar_hs && rd_idx == rpo_pkg::IDX_PORT);
   COV_ANA_OUT: cover property (@(posedge CLK_SYS) disable iff (!RSTN) CE && ana_q[0] && !dir_q[0]);
endmodule // rpo_pin_output_select
`default_nettype wire

// File: rpo_pin_model.sv
// Pad model for the four remappable pins: block drive, outside driver, weak pulls.
// Assumes one clock; a free pad toggles each cycle so a stale level never passes.
`timescale 1ns/100ps
`default_nettype none
module rpo_pin_model (
   // Clock
   input  wire logic       clk,
   // Block side
   input  wire logic [3:0] pin_out,
   input  wire logic [3:0] pin_oe,
   input  wire logic [3:0] pu_en,
   input  wire logic [3:0] pd_en,
   // Outside driver
   input  wire logic [3:0] ext_en,
   input  wire logic [3:0] ext_val,
   // Pad level
   output logic      [3:0] pin_in
);
   logic [3:0] float_q = 4'h0;
   always @(posedge clk) begin
      float_q <= ~float_q;
   end
   // Block drive wins; pulls act only on a pad nobody drives
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         if (pin_oe[i]) begin
            pin_in[i] = pin_out[i];
         end else if (ext_en[i]) begin
            pin_in[i] = ext_val[i];
         end else if (pu_en[i] | pd_en[i]) begin
            pin_in[i] = pu_en[i];
         end else begin
            pin_in[i] = float_q[i];
         end
      end
   end
endmodule // rpo_pin_model
`default_nettype wire

// File: remappable_pin_output_select_test.sv
// Self-checking bench for the remappable pin output select block.
// Assumes the pad model beside it and the package map.
`timescale 1ns/100ps
`default_nettype none
module remappable_pin_output_select_test;
   logic        clk_sys = 1'b0;
   logic        rst_n = 1'b0;
   logic        ce = 1'b1;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [2:0]  prot = 3'h0;
   logic [3:0]  wstrb = 4'hF, ded_en = 4'h0, ded_out = 4'h0, ext_en = 4'h0, ext_val = 4'h0;
   logic [31:0] wdata = 32'h0, periph = 32'h0, rdata, r, v;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   logic [3:0]  dig_in, pin_in, pin_out, pin_oe, pu_en, pd_en, an_en, dir_m, lat_m;
   logic [4:0]  code_m [4];
   int          fail_count = 0, check_count = 0, cycles = 0;

   always #2.5 clk_sys = ~clk_sys;

   rpo_pin_output_select dut (.CLK_SYS(clk_sys), .RSTN(rst_n), .CE(ce), .AWVALID(awvalid), .AWREADY(awready),
      .AWADDR(awaddr), .AWPROT(prot), .WVALID(wvalid), .WREADY(wready), .WDATA(wdata), .WSTRB(wstrb),
      .BVALID(bvalid), .BREADY(bready), .BRESP(bresp), .ARVALID(arvalid), .ARREADY(arready), .ARADDR(araddr),
      .ARPROT(prot), .RVALID(rvalid), .RREADY(rready), .RDATA(rdata), .RRESP(rresp), .PERIPH_OUT(periph),
      .DED_OUT_EN(ded_en), .DED_OUT(ded_out), .DIG_IN(dig_in), .PIN_IN(pin_in), .PIN_OUT(pin_out),
      .PIN_OE(pin_oe), .PIN_PU_EN(pu_en), .PIN_PD_EN(pd_en), .PIN_ANALOG_EN(an_en));
   rpo_pin_model pads (.clk(clk_sys), .pin_out(pin_out), .pin_oe(pin_oe), .pu_en(pu_en), .pd_en(pd_en),
      .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Dedicated first, then a nonzero code, then the direction bit
   function automatic logic [3:0] exp_oe();
      for (int i = 0; i < 4; i++) exp_oe[i] = ded_en[i] | (code_m[i] != 5'h00) | ~dir_m[i];
   endfunction
   function automatic logic [3:0] exp_out();
      for (int i = 0; i < 4; i++)
         exp_out[i] = ded_en[i] ? ded_out[i] : ((code_m[i] != 5'h00) ? periph[code_m[i]] : lat_m[i]);
   endfunction

   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
      chk({28'h0, got}, {28'h0, exp});
   endtask
   // Handshakes are sampled at the falling edge, acted on at the next rising one
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw_d, w_d, aw_t, w_t;
      aw_d = 1'b0;
      w_d = 1'b0;
      @(posedge clk_sys);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= d;
      bready <= 1'b1;
      while (!(aw_d && w_d)) begin
         @(negedge clk_sys);
         aw_t = awvalid & awready;
         w_t = wvalid & wready;
         @(posedge clk_sys);
         if (aw_t) awvalid <= 1'b0;
         if (w_t) wvalid <= 1'b0;
         aw_d = aw_d | aw_t;
         w_d = w_d | w_t;
      end
      do @(negedge clk_sys); while (!bvalid);
      chk({30'h0, bresp}, {30'h0, er});
      @(posedge clk_sys);
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge clk_sys);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      do @(negedge clk_sys); while (!arready);
      @(posedge clk_sys);
      arvalid <= 1'b0;
      do @(negedge clk_sys); while (!rvalid);
      chk(rdata, e);
      chk({30'h0, rresp}, {30'h0, er});
      @(posedge clk_sys);
      rready <= 1'b0;
   endtask

   // Hang guard, well above the several hundred cycles the run needs
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         fail_count++;
         test_done();
      end
   end

   initial begin
      r = 32'h85C4D7FE;
      repeat (10) @(posedge clk_sys);
      rst_n <= 1'b1;
      rd(rpo_pkg::OFS_OSEL_A, 32'h0, 2'h0);
      rd(rpo_pkg::OFS_OSEL_B, 32'h0, 2'h0);
      rd(rpo_pkg::OFS_ANSEL, 32'hF, 2'h0);
      chk_pin(an_en, 4'hF);
      // Analog pads driven high from outside must still read low
      ext_en <= 4'hF;
      ext_val <= 4'hF;
      wr(rpo_pkg::OFS_LAT, 32'hF, 2'h0);
      repeat (6) @(posedge clk_sys);
      chk_pin(dig_in, 4'h0);
      rd(rpo_pkg::OFS_PORT, 32'h0, 2'h0);
      rd(rpo_pkg::OFS_LAT, 32'h0, 2'h0);
      wr(rpo_pkg::OFS_ANSEL, 32'h0, 2'h0);
      repeat (6) @(posedge clk_sys);
      chk_pin(dig_in, 4'hF);
      rd(rpo_pkg::OFS_PORT, 32'hF, 2'h0);
      wr(rpo_pkg::OFS_ANSEL, 32'hF, 2'h0);
      ext_en <= 4'h0;
      wr(rpo_pkg::OFS_DIR, 32'h0, 2'h0);
      repeat (4) @(posedge clk_sys);
      chk_pin(pin_oe, 4'hF);
      chk_pin(pin_out, 4'hF);
      wr(rpo_pkg::OFS_ANSEL, 32'h0, 2'h0);
      wr(rpo_pkg::OFS_OSEL_A, 32'hFFFFFFFF, 2'h0);
      rd(rpo_pkg::OFS_OSEL_A, 32'h1F1F, 2'h0);
      wr(rpo_pkg::OFS_OSEL_B, 32'hFFFFFFFF, 2'h0);
      rd(rpo_pkg::OFS_OSEL_B, 32'h1F1F, 2'h0);
      wr(8'h40, 32'hFFFFFFFF, 2'h2);
      rd(8'h40, 32'h0, 2'h2);
      // Random codes, sources and directions; first pass all codes zero
      for (int k = 0; k < 24; k++) begin
         r = lfsr(r);
         v = (k == 0) ? 32'h0 : r;
         wr(rpo_pkg::OFS_OSEL_A, v, 2'h0);
         code_m[0] = v[4:0];
         code_m[1] = v[12:8];
         r = lfsr(r);
         v = (k == 0) ? 32'h0 : r;
         wr(rpo_pkg::OFS_OSEL_B, v, 2'h0);
         code_m[2] = v[4:0];
         code_m[3] = v[12:8];
         r = lfsr(r);
         dir_m = r[3:0];
         lat_m = r[7:4];
         wr(rpo_pkg::OFS_DIR, {28'h0, dir_m}, 2'h0);
         wr(rpo_pkg::OFS_LAT, {28'h0, lat_m}, 2'h0);
         r = lfsr(r);
         periph <= r;
         ded_en <= (k == 0) ? 4'h0 : r[3:0] & r[7:4];
         ded_out <= r[11:8];
         repeat (6) @(posedge clk_sys);
         chk_pin(pin_oe, exp_oe());
         chk_pin(pin_out, exp_out());
         chk_pin(dig_in & exp_oe(), exp_out() & exp_oe());
      end
      // Pulls on free pads
      ded_en <= 4'h0;
      wr(rpo_pkg::OFS_OSEL_A, 32'h0, 2'h0);
      // Low byte strobe only: pin 13 code must stay zero
      wstrb <= 4'h1;
      wr(rpo_pkg::OFS_OSEL_A, 32'h00001F1F, 2'h0);
      wstrb <= 4'hF;
      rd(rpo_pkg::OFS_OSEL_A, 32'h0000001F, 2'h0);
      wr(rpo_pkg::OFS_OSEL_A, 32'h0, 2'h0);
      wr(rpo_pkg::OFS_OSEL_B, 32'h0, 2'h0);
      wr(rpo_pkg::OFS_DIR, 32'hF, 2'h0);
      wr(rpo_pkg::OFS_PU, 32'h5, 2'h0);
      wr(rpo_pkg::OFS_PD, 32'hA, 2'h0);
      repeat (6) @(posedge clk_sys);
      chk_pin(pu_en, 4'h5);
      chk_pin(pd_en, 4'hA);
      chk_pin(dig_in, 4'h5);
      rd(rpo_pkg::OFS_PD, 32'hA, 2'h0);
      // Frozen clock enable holds the pins; release lets dedicated drive in
      ce <= 1'b0;
      ded_en <= 4'hF;
      ded_out <= 4'h0;
      repeat (4) @(posedge clk_sys);
      chk_pin(pin_oe, 4'h0);
      ce <= 1'b1;
      repeat (3) @(posedge clk_sys);
      chk_pin(pin_oe, 4'hF);
      chk_pin(pin_out, 4'h0);
      test_done();
   end
endmodule // remappable_pin_output_select_test
`default_nettype wire
